// ===== rtl/tlct_pkg.sv
/*
 * shared constants and types of the traffic light cycle timer:
 * cycle figures, timing constants, view selection and the state record.
 * assumes one system clock; figures below are in seconds, nanoseconds or clock cycles.
 */
package tlct_pkg;

    // ************************************************************
    // cycle figures
    // ************************************************************
    localparam int          SLOT_SECONDS  = 20;
    localparam int          CYCLE_SECONDS = 80;
    localparam int          YELLOW_AT     = 15;
    localparam logic [4:0]  BASE_RST      = 5'h14;
    localparam logic [4:0]  BASE_LAST     = 5'h01;
    localparam logic [1:0]  PHASE_RST     = 2'h0;
    localparam logic [6:0]  TIMER_RST     = 7'h00;
    localparam logic [6:0]  SLOT_STEP     = 7'h14;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint      SECOND_NS     = 1000000000;
    localparam longint      SCAN_NS       = 1000000;
    localparam longint      CLK_PERIOD_NS = 4;
    localparam int          TICK_CYCLES   = int'(SECOND_NS / CLK_PERIOD_NS);
    localparam int          SCAN_CYCLES   = int'(SCAN_NS / CLK_PERIOD_NS);
    localparam int          DIV_W         = 28;
    localparam int          SCAN_W        = 20;

    // ************************************************************
    // direction numbering and view selection
    // ************************************************************
    localparam logic [1:0]  DIR_N = 2'h0;
    localparam logic [1:0]  DIR_E = 2'h1;
    localparam logic [1:0]  DIR_S = 2'h2;
    localparam logic [1:0]  DIR_W = 2'h3;

    typedef enum logic [2:0] {
        VIEW_NONE,
        VIEW_N,
        VIEW_E,
        VIEW_S,
        VIEW_W
    } tlct_view_t;

    typedef struct packed {
        logic [6:0] segs;
        logic [1:0] digit_en;
    } tlct_disp_t;

    typedef struct packed {
        logic [3:0] green;
        logic [3:0] yellow;
        logic [3:0] red;
    } tlct_lights_t;

    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic [4:0]        base;
        logic [1:0]        phase;
        tlct_view_t        view;
        logic [6:0]        timer;
        logic [SCAN_W-1:0] scan;
        logic              digit_sel;
        tlct_disp_t        disp;
        tlct_lights_t      lights;
    } tlct_state_t;

endpackage : tlct_pkg

// ===== rtl/tlct_bcd_rom.sv
/*
 * binary to two-digit decimal lookup for values 0 to 99, registered read.
 * assumes a synchronous reset copy and a clock enable from the parent.
 */
`timescale 1ns/1ns
`default_nettype none

module tlct_bcd_rom
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [6:0] addr,
    output var  logic [7:0] rd_data
);

    // ************************************************************
    // table
    // ************************************************************
    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        logic [3:0] tens;
        logic [6:0] rest;
        tens = 4'h0;
        rest = v;
        for (int i = 0; i < 12; i++)
        begin
            if (rest >= 7'h0a)
            begin
                rest = rest - 7'h0a;
                tens = tens + 4'h1;
            end
        end
        return {tens, rest[3:0]};
    endfunction : to_bcd

    // exact for codes 0 to 99, so no hand-typed entry can slip
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= 8'h00;
        else if (ce)
            rd_data <= to_bcd(addr); // see R6
    end

endmodule : tlct_bcd_rom
`default_nettype wire

// ===== rtl/tlct_top.sv
/*
 * traffic light cycle timer: shared one-second countdown, rotating
 * direction offsets, light outputs and a multiplexed two-digit display.
 * assumes buttons and ce synchronous to clk, buttons active high.
 */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1 - with no view chosen after reset both display digits show zero.
// R2 - a north view chosen at reset starts at count 14 hex, shown as 20.
// R3 - an east view chosen at reset starts at count 50 hex, shown as 80.
// R4 - a south view chosen at reset starts at count 3c hex, shown as 60.
// R5 - a west view chosen at reset starts at count 28 hex, shown as 40.
// R6 - the binary count is shown as decimal through an exact lookup.
// R7 - the shown timer drops by exactly one per step from 80 to 1, then wraps to 80, never skipping.
// R8 - each direction's count is the shared base plus its own offset.
// R9 - offsets change every 20 seconds, rotating through 0, 60, 40, 20.
// R10 - neighbouring offsets and successive offsets differ by 20.
// R11 - green at 20, yellow at 15, red when the slot ends, each 80 s.
// R12 - the one-second steps are derived from the input clock.
// R13 - each digit enable is on only while its digit is on the bus.
// R14 - the user picks the shown direction with one of four buttons.
// R15 - reset loads base count 20 and clears the offset phase and view selection.
// R16 - a divided one-second tick advances the base count.
module tlct_top
#(
    parameter int TICK_CYCLES = tlct_pkg::TICK_CYCLES,
    parameter int SCAN_CYCLES = tlct_pkg::SCAN_CYCLES
)
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       view_button_n,
    input  wire logic       view_button_e,
    input  wire logic       view_button_s,
    input  wire logic       view_button_w,
    output var  logic [6:0] seg_data,
    output var  logic [1:0] digit_en,
    output var  logic [7:0] count_hex,
    output var  logic [3:0] light_green,
    output var  logic [3:0] light_yellow,
    output var  logic [3:0] light_red
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    assign rst_n = rst_sync_reg[1];

    // ************************************************************
    // helpers
    // ************************************************************
    // offset rank: north 0, west 1, south 2, east 3 at phase 0
    function automatic logic [6:0] dir_value(input logic [4:0] base,
                                             input logic [1:0] phase,
                                             input logic [1:0] dir);
        logic [1:0] rank;
        logic [6:0] offs;
        rank = 2'(2'h0 - dir - phase);
        offs = 7'(rank * tlct_pkg::SLOT_STEP);
        return 7'(base) + offs; // see R8 see R10
    endfunction : dir_value

    // active-high gfedcba
    function automatic logic [6:0] seg_of(input logic [3:0] d);
        unique case (d)
            4'h0:    return 7'h3f;
            4'h1:    return 7'h06;
            4'h2:    return 7'h5b;
            4'h3:    return 7'h4f;
            4'h4:    return 7'h66;
            4'h5:    return 7'h6d;
            4'h6:    return 7'h7d;
            4'h7:    return 7'h07;
            4'h8:    return 7'h7f;
            4'h9:    return 7'h6f;
            default: return 7'h00;
        endcase
    endfunction : seg_of

    // ************************************************************
    // state
    // ************************************************************
    tlct_pkg::tlct_state_t st_reg;
    tlct_pkg::tlct_state_t st_next;
    logic [7:0]            bcd;
    logic                  tick;
    logic                  scan_wrap;
    logic [6:0]            dval [4];

    tlct_bcd_rom u_rom
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .addr    (st_reg.timer),
        .rd_data (bcd)
    );

    assign tick      = (st_reg.div == tlct_pkg::DIV_W'(TICK_CYCLES - 1));
    assign scan_wrap = (st_reg.scan == tlct_pkg::SCAN_W'(SCAN_CYCLES - 1));

    always_comb
    begin
        for (int d = 0; d < 4; d++)
            dval[d] = dir_value(st_reg.base, st_reg.phase, 2'(d));
    end

    always_comb
    begin
        st_next = st_reg;

        // one-second divider
        st_next.div = tick ? '0 : st_reg.div + 1'b1; // see R12 see R16
        if (tick)
        begin
            if (st_reg.base == tlct_pkg::BASE_LAST)
            begin
                // wraps from 1 to 20 while offsets step down by one slot
                st_next.base  = tlct_pkg::BASE_RST; // see R7 see R9
                st_next.phase = st_reg.phase + 2'h1; // see R9 see R10
            end
            else
                st_next.base = st_reg.base - 5'h01; // see R16
        end

        // a pressed button sets the view, north before east, south, west; a button held through reset counts on release
        if (view_button_n)
            st_next.view = tlct_pkg::VIEW_N; // see R14
        else if (view_button_e)
            st_next.view = tlct_pkg::VIEW_E;
        else if (view_button_s)
            st_next.view = tlct_pkg::VIEW_S;
        else if (view_button_w)
            st_next.view = tlct_pkg::VIEW_W;

        unique case (st_reg.view)
            tlct_pkg::VIEW_NONE: st_next.timer = tlct_pkg::TIMER_RST; // see R1
            tlct_pkg::VIEW_N:    st_next.timer = dval[tlct_pkg::DIR_N]; // see R2
            tlct_pkg::VIEW_E:    st_next.timer = dval[tlct_pkg::DIR_E]; // see R3
            tlct_pkg::VIEW_S:    st_next.timer = dval[tlct_pkg::DIR_S]; // see R4
            tlct_pkg::VIEW_W:    st_next.timer = dval[tlct_pkg::DIR_W]; // see R5
            default:             st_next.timer = tlct_pkg::TIMER_RST;
        endcase

        // lights per direction
        for (int d = 0; d < 4; d++)
        begin
            st_next.lights.green[d]  = (dval[d] > 7'(tlct_pkg::YELLOW_AT))
                && (dval[d] <= 7'(tlct_pkg::SLOT_SECONDS)); // see R11
            st_next.lights.yellow[d] = (dval[d] <= 7'(tlct_pkg::YELLOW_AT));
            st_next.lights.red[d]    = (dval[d] > 7'(tlct_pkg::SLOT_SECONDS));
        end

        // digit multiplex: data and enable change on the same edge
        st_next.scan = scan_wrap ? '0 : st_reg.scan + 1'b1;
        if (scan_wrap)
            st_next.digit_sel = ~st_reg.digit_sel;
        st_next.disp.segs = st_reg.digit_sel ? seg_of(bcd[7:4])
                                             : seg_of(bcd[3:0]); // see R6
        st_next.disp.digit_en = st_reg.digit_sel ? 2'b10 : 2'b01; // see R13
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg                 <= '0; // see R15
            st_reg.base            <= tlct_pkg::BASE_RST;
            st_reg.phase           <= tlct_pkg::PHASE_RST;
            st_reg.view            <= tlct_pkg::VIEW_NONE;
            st_reg.timer           <= tlct_pkg::TIMER_RST;
            st_reg.disp.segs       <= 7'h3f;
            st_reg.disp.digit_en   <= 2'b01;
        end
        else if (ce)
            st_reg <= st_next;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // count_hex mirrors the timer flop so the hex count and the
    // decimal digits can be compared side by side
    assign seg_data     = st_reg.disp.segs;
    assign digit_en     = st_reg.disp.digit_en;
    assign count_hex    = {1'b0, st_reg.timer};
    assign light_green  = st_reg.lights.green;
    assign light_yellow = st_reg.lights.yellow;
    assign light_red    = st_reg.lights.red;

endmodule : tlct_top
`default_nettype wire

// ===== dv/tlct_monitor.sv
/* checker for tlct_top, attached by bind.
   assumes buttons driven by the panel model; second length counts
   only enabled clocks, since ce low freezes the divider. */
`timescale 1ns/1ns
`default_nettype none
module tlct_monitor
#(
    parameter int TICK_CYCLES = 20
)
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic       view_button_n,
    input wire logic       view_button_e,
    input wire logic       view_button_s,
    input wire logic       view_button_w,
    input wire logic [6:0] seg_data,
    input wire logic [1:0] digit_en,
    input wire logic [7:0] count_hex,
    input wire logic [3:0] light_green,
    input wire logic [3:0] light_yellow,
    input wire logic [3:0] light_red
);
    // ************************************************************
    // helpers
    // ************************************************************
    logic [3:0]  quiet_reg;
    logic [1:0]  seen_reg;
    logic [7:0]  last_reg;
    logic [31:0] run_reg;
    logic        btn;
    logic        ok;
    logic        chg;
    assign btn = view_button_n | view_button_e | view_button_s | view_button_w;
    // a view change jumps the count, so checks wait for a quiet spell
    assign ok  = quiet_reg == 4'hf;
    assign chg = count_hex != last_reg;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            quiet_reg <= 4'h0;
            seen_reg  <= 2'h0;
        end
        else
        begin
            quiet_reg <= btn ? 4'h0 : quiet_reg + {3'h0, !ok};
            seen_reg  <= btn ? 2'h0 : seen_reg + {1'b0, chg && !seen_reg[1]};
        end
    end
    always_ff @(posedge clk)
    begin
        last_reg <= count_hex;
        run_reg  <= chg ? 32'h0 : run_reg + {31'h0, ce};
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    digit_hot_a: assert property (
        digit_en inside {2'h1, 2'h2}) else $error("digit enable bad");
    count_max_a: assert property (
        count_hex <= 8'h50) else $error("count above 80");
    count_step_a: assert property (
        ok && chg && last_reg != 8'h0 |-> count_hex == last_reg - 8'h1
        || (last_reg == 8'h1 && count_hex == 8'h50)) else $error("bad step");
    tick_len_a: assert property (
        ok && chg && seen_reg == 2'h2 |-> run_reg == 32'(TICK_CYCLES - 1))
        else $error("second length wrong");
    light_one_a: assert property (
        ok |-> (light_green | light_yellow | light_red) == 4'hf
        && ((light_green & light_yellow) | (light_yellow & light_red)) == 4'h0
        && ((light_green | light_yellow) & light_red) == 4'h0)
        else $error("light mix");
    one_go_a: assert property (
        ok |-> $countones(~light_red) == 1) else $error("not one go");
    green_band_a: assert property (
        ok && count_hex inside {[8'h10:8'h14]} |-> light_green != 4'h0)
        else $error("no green");
    zero_show_a: assert property (
        count_hex == 8'h0 |-> seg_data == 7'h3f) else $error("not zero");
endmodule : tlct_monitor
bind tlct_top tlct_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk(clk),
    .rstn(rstn), .ce(ce), .view_button_n(view_button_n),
    .view_button_e(view_button_e),
    .view_button_s(view_button_s), .view_button_w(view_button_w),
    .seg_data(seg_data), .digit_en(digit_en), .count_hex(count_hex),
    .light_green(light_green), .light_yellow(light_yellow),
    .light_red(light_red));
`default_nettype wire

// ===== dv/tlct_panel.sv
/* buttons and two-digit display of the panel.
   assumes press is set by the bench just after a clock edge. */
`timescale 1ns/1ns
`default_nettype none
module tlct_panel
(
    input  wire logic       clk,
    input  wire logic [2:0] press,
    input  wire logic [6:0] seg_data,
    input  wire logic [1:0] digit_en,
    output var  logic [3:0] btn,
    output var  logic [6:0] shown
);
    logic [3:0] ones_reg;
    logic [3:0] tens_reg;
    function automatic logic [3:0] glyph(input logic [6:0] s);
        case (s)
            7'h3f: glyph = 4'h0;
            7'h06: glyph = 4'h1;
            7'h5b: glyph = 4'h2;
            7'h4f: glyph = 4'h3;
            7'h66: glyph = 4'h4;
            7'h6d: glyph = 4'h5;
            7'h7d, 7'h7c: glyph = 4'h6;
            7'h07, 7'h27: glyph = 4'h7;
            7'h7f: glyph = 4'h8;
            7'h6f, 7'h67: glyph = 4'h9;
            default: glyph = 4'hf;
        endcase
    endfunction : glyph
    // one button at a time, n e s w
    assign btn = press == 3'h0 ? 4'h0 : 4'h1 << (press - 3'h1);
    // a digit takes the bus only while enabled
    always_ff @(posedge clk)
    begin
        if (digit_en[0])
            ones_reg <= glyph(seg_data);
        if (digit_en[1])
            tens_reg <= glyph(seg_data);
    end
    assign shown = 7'(tens_reg) * 7'h0a + 7'(ones_reg);
endmodule : tlct_panel
`default_nettype wire

// ===== dv/tb.sv
/* self-checking bench of tlct_top with shortened counts.
   assumes 4 ns clock; ce is dropped only in the hold test. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       ce = 1'b1;
    logic [2:0] press = 3'h0;
    logic [3:0] btn;
    logic [6:0] shown;
    logic [6:0] seg;
    logic [1:0] den;
    logic [7:0] cnt;
    logic [3:0] lg;
    logic [3:0] ly;
    logic [3:0] lr;
    int         miscompares = 0;
    int         n_compared = 0;
    int         n;
    always #2 clk = ~clk;
    tlct_top #(.TICK_CYCLES(20), .SCAN_CYCLES(3)) u_dut (.clk(clk),
        .rstn(rstn), .ce(ce), .view_button_n(btn[0]),
        .view_button_e(btn[1]), .view_button_s(btn[2]),
        .view_button_w(btn[3]), .seg_data(seg), .digit_en(den),
        .count_hex(cnt), .light_green(lg), .light_yellow(ly),
        .light_red(lr));
    tlct_panel u_panel (.clk(clk), .press(press), .seg_data(seg),
        .digit_en(den), .btn(btn), .shown(shown));
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    // button held through reset, dropped after release
    task automatic restart(input logic [2:0] p);
        press = p;
        rstn = 1'b0;
        step(2);
        rstn = 1'b1;
        step(4);
        press = 3'h0;
    endtask : restart
    task automatic wait_chg;
        logic [7:0] v;
        int         i;
        v = cnt;
        for (i = 0; i < 40 && cnt === v; i++)
            step(1);
        if (cnt === v)
        begin
            check(8'h0, 8'h1);
            end_sim();
        end
        else
            n = n == 1 ? 80 : n - 1;
    endtask : wait_chg
    task automatic t_idle;
        restart(3'h0);
        step(60);
        check(cnt, 8'h00);
        check({1'b0, shown}, 8'h00);
        $display("idle test done");
    endtask : t_idle
    task automatic t_views;
        logic [7:0] hx [4] = '{8'h14, 8'h50, 8'h3c, 8'h28};
        int         dec [4] = '{20, 80, 60, 40};
        for (int d = 0; d < 4; d++)
        begin
            restart(3'(d + 1));
            step(4);
            check(cnt, hx[d]);
            step(8);
            check({1'b0, shown}, 8'(dec[d]));
        end
        $display("view start test done");
    endtask : t_views
    task automatic t_count;
        restart(3'h1);
        step(4);
        n = 20;
        for (int k = 0; k < 81; k++)
        begin
            wait_chg();
            step(10);
            check(cnt, 8'(n));
            check({1'b0, shown}, 8'(n));
            check({5'h00, lg[0], ly[0], lr[0]},
                n > 20 ? 8'h01 : n > 15 ? 8'h04 : 8'h02);
        end
        $display("countdown test done");
    endtask : t_count
    // ce low across two would-be ticks must freeze the count;
    // dropped two edges after a change so the second length still holds
    task automatic t_hold;
        wait_chg();
        step(2);
        ce = 1'b0;
        step(40);
        check(cnt, 8'(n));
        ce = 1'b1;
        step(1);
        check(cnt, 8'(n));
        $display("hold test done");
    endtask : t_hold
    task automatic t_switch;
        logic [2:0] p [4] = '{3'h2, 3'h3, 3'h4, 3'h1};
        int         off [4] = '{60, 40, 20, 0};
        for (int d = 0; d < 4; d++)
        begin
            wait_chg();
            step(2);
            press = p[d];
            step(1);
            press = 3'h0;
            step(8);
            check(cnt, 8'((n + off[d] - 1) % 80 + 1));
        end
        $display("switch test done");
    endtask : t_switch
    initial
    begin
        t_idle();
        t_views();
        t_count();
        t_hold();
        t_switch();
        end_sim();
    end
endmodule : tb
`default_nettype wire
